/* File: fpc_consts.svh */
// Constants, register map and timing counts of the front-panel controller.
// Summary of operation
// - Source key picks input pair; step key cycles left, right, both.
// - Gain shows as one flashing LED in left meters; encoder sets it.
// - Input meters show overload of any input in every view except the power-on mode display.
// - Target key picks one of three outputs; encoder sets level, flashing dot.
// - Output meters show overload of any output in every view except the power-on mode display.
// - Step held on an output: two yellow bars; encoder sets balance.
// - Dim acts on the main output only; dim LEDs dark on other outputs.
// - Holding attenuate key two seconds recalls the saved main volume.
// - Holding store key two seconds saves the current main volume.
// - Monitor: pick output, input, press monitor key, channel, level.
// - Monitoring has no panorama; optical source covers its first two channels.
// - Optical output selected, store key shows format; step key toggles it.
// - Stand-alone with optical input active, left meters show detected format in gain and output views.
// - Online, store, monitor and target keys may be handed to the host.
// - Brightness starts at 25%; step held plus source press advances it.
// - Power-on shows host mode; step and attenuate held at power-on toggle it.
// - External supply without USB, long combo hold toggles mode repeatedly.
// - Optical LED yellow no signal, flashing green locked, green synced.
// - Lowest LED shows phantom or dim; top LED lights red on clipping.
`ifndef FPC_CONSTS_SVH
`define FPC_CONSTS_SVH
`define FPC_CLK_MHZ 100
`define FPC_TICK_US 1000
`define FPC_HOLD_MS 2000
`define FPC_BOOT_MS 1000
`define FPC_K_SRC 0
`define FPC_K_TGT 1
`define FPC_K_STEP 2
`define FPC_K_ATT 3
`define FPC_K_STO 4
`define FPC_K_MON 5
`define FPC_OPT_SRC 2'h2
`define FPC_OPT_OUT 2'h2
`define FPC_GAIN_MAX 7'h3F
`define FPC_LVL_MAX 7'h7F
`define FPC_BAL_MAX 7'h1F
`define FPC_MON_MAX 7'h3F
`define FPC_BAL_RST 5'h10
`define FPC_LVL_RST 7'h40
`define FPC_BAR_YEL 8'h7F
`define FPC_FMT_8CH 8'hFF
`define FPC_FMT_2CH 8'h03
`define FPC_PAT_CC 8'h3C
`define FPC_PAT_DRV 8'hC3
`define FPC_CLIP_BIT 7
`define FPC_A_CTRL 8'h00
`define FPC_A_DIMATT 8'h04
`define FPC_A_STATUS 8'h08
`define FPC_A_GAIN 8'h0C
`define FPC_A_LEVEL 8'h10
`define FPC_A_BAL 8'h14
`define FPC_A_SAVED 8'h18
`define FPC_A_MON 8'h1C
`define FPC_A_EVENT 8'h20
`define FPC_RESP_OK 2'h0
`define FPC_RESP_ERR 2'h2
`endif

/* File: fpc_pkg.sv */
// Types of the front-panel controller.
package fpc_pkg;
    typedef struct packed {
        logic monitor;
        logic store;
        logic attenuate;
        logic step;
        logic target;
        logic source;
    } fpc_keys_t;

    typedef enum logic [4:0] {
        FPC_BOOT = 5'h01,
        FPC_GAIN = 5'h02,
        FPC_OUT  = 5'h04,
        FPC_MON  = 5'h08,
        FPC_FMT  = 5'h10
    } fpc_view_t;

    typedef struct packed {
        logic [16:0]      tick_cnt;
        logic [8:0]       tfree;
        logic [5:0][3:0]  deb;
        logic [5:0]       key;
        logic [5:0]       keyp;
        logic             enc_a;
        fpc_view_t        st;
        logic             booted;
        logic [11:0]      boot_cnt;
        logic [1:0]       in_sel;
        logic [1:0]       in_ch;
        logic [1:0]       out_sel;
        logic [3:0][5:0]  gain;
        logic [2:0][6:0]  lvl;
        logic [2:0][4:0]  bal;
        logic [8:0][5:0]  mon;
        logic [6:0]       saved;
        logic [6:0]       main_lvl;
        logic             dim_on;
        logic             opt_8ch;
        logic             host_cc;
        logic [1:0]       bright;
        logic [1:0]       pwm_cnt;
        logic [11:0]      hold_dim;
        logic [11:0]      hold_set;
        logic [11:0]      hold_mode;
        logic             dim_fired;
        logic             set_fired;
        logic [7:0]       ctrl;
        logic [5:0]       dim_att;
        logic [2:0]       events;
        logic [3:0][7:0]  meter;
        logic             opt_y;
        logic             opt_g;
        logic             pwm_on;
        logic             aw_have;
        logic [7:0]       aw_addr;
        logic             w_have;
        logic [31:0]      w_data;
        logic [3:0]       w_strb;
        logic             awready;
        logic             wready;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             arready;
        logic             rvalid;
        logic [1:0]       rresp;
        logic [31:0]      rdata;
    } fpc_state_t;
endpackage

/* File: fpc_front_panel.sv */
// Front-panel controller: keys, encoder, meters and AXI4-Lite registers.
`timescale 1ns/1ns
`include "fpc_consts.svh"
module fpc_front_panel #(
    parameter int unsigned TICK_CYC   = `FPC_TICK_US * `FPC_CLK_MHZ,
    parameter int unsigned HOLD_TICKS = `FPC_HOLD_MS * 1000 / `FPC_TICK_US,
    parameter int unsigned BOOT_TICKS = `FPC_BOOT_MS * 1000 / `FPC_TICK_US
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire fpc_pkg::fpc_keys_t keys,
    input  wire logic              enc_a,
    input  wire logic              enc_b,
    input  wire logic              host_online,
    input  wire logic              usb_present,
    input  wire logic              ext_power,
    input  wire logic              opt_lock,
    input  wire logic              opt_sync,
    input  wire logic              opt_in_8ch,
    input  wire logic [3:0][2:0]   band_level,
    input  wire logic [2:0]        in_clip,
    input  wire logic [2:0]        out_clip,
    input  wire logic [7:0]        awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [7:0]        araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    output logic [3:0][7:0]        meter,
    output logic                   opt_led_yellow,
    output logic                   opt_led_green,
    output logic                   led_pwm,
    output logic                   dim_active,
    output logic                   host_cc_mode,
    output logic [6:0]             main_level
);
    fpc_pkg::fpc_state_t q;
    fpc_pkg::fpc_state_t d;
    logic [5:0]  kraw;
    logic [5:0]  press;
    logic        tick;
    logic        up;
    logic        dn;
    logic        flash;
    logic        combo;
    logic [2:0]  remap;
    logic [1:0]  main_sel;
    logic [3:0]  mi;
    logic [32:0] wcur;
    logic [32:0] rcur;
    logic [31:0] wd;
    logic [6:0]  att;

    function automatic logic [6:0] stepv(logic [6:0] v, logic u,
                                         logic [6:0] mx);
        if (u)
        begin
            return (v >= mx) ? v : v + 7'h01;
        end
        return (v == 7'h00) ? v : v - 7'h01;
    endfunction

    function automatic logic [7:0] bar(logic [2:0] n);
        return 8'((9'h001 << n) - 9'h001);
    endfunction

    function automatic logic [7:0] dot(logic [2:0] p);
        return 8'h01 << p;
    endfunction

    function automatic logic [3:0] midx(logic [1:0] o, logic [1:0] i);
        return 4'(4'(o) * 4'h3 + 4'(i));
    endfunction

    function automatic logic [32:0] rb(fpc_pkg::fpc_state_t s,
                                       logic [7:0] a);
        logic [3:0] m;
        m = midx(s.out_sel, s.in_sel);
        case ({a[7:2], 2'b00})
            `FPC_A_CTRL:   rb = {1'b1, 24'h0, s.ctrl};
            `FPC_A_DIMATT: rb = {1'b1, 26'h0, s.dim_att};
            `FPC_A_STATUS: rb = {1'b1, 16'h0, s.in_ch, s.out_sel, s.in_sel,
                                 s.dim_on, s.bright, s.opt_8ch, s.host_cc,
                                 5'(s.st)};
            `FPC_A_GAIN:   rb = {1'b1, 8'h0, s.gain};
            `FPC_A_LEVEL:  rb = {1'b1, 11'h0, s.lvl};
            `FPC_A_BAL:    rb = {1'b1, 17'h0, s.bal};
            `FPC_A_SAVED:  rb = {1'b1, 25'h0, s.saved};
            `FPC_A_MON:    rb = {1'b1, 26'h0, s.mon[m]};
            `FPC_A_EVENT:  rb = {1'b1, 29'h0, s.events};
            default:       rb = 33'h0;
        endcase
    endfunction

    always_comb
    begin
        d = q;
        kraw = 6'(keys);
        up = 1'b0;
        dn = 1'b0;
        flash = q.tfree[8];
        combo = q.key[`FPC_K_STEP] & q.key[`FPC_K_ATT];
        remap = host_online ? q.ctrl[4:2] : 3'h0;
        main_sel = q.ctrl[1:0];
        mi = midx(q.out_sel, q.in_sel);
        wcur = rb(q, q.aw_addr);
        rcur = rb(q, araddr);
        wd = 32'h0;
        tick = (q.tick_cnt == 17'(TICK_CYC - 1));

        d.tick_cnt = tick ? 17'h00000 : q.tick_cnt + 17'h00001;
        if (tick)
        begin
            d.tfree = q.tfree + 9'h001;
            for (int i = 0; i < 6; i++)
            begin
                d.deb[i] = {q.deb[i][2:0], kraw[i]};
                if (d.deb[i] == 4'hF)
                    d.key[i] = 1'b1;
                else if (d.deb[i] == 4'h0)
                    d.key[i] = 1'b0;
            end
        end
        d.keyp = q.key;
        press = q.key & ~q.keyp;
        d.enc_a = enc_a;
        if (enc_a && !q.enc_a)
        begin
            up = !enc_b;
            dn = enc_b;
        end

        if (awvalid && q.awready)
        begin
            d.aw_have = 1'b1;
            d.aw_addr = awaddr;
        end
        if (wvalid && q.wready)
        begin
            d.w_have = 1'b1;
            d.w_data = wdata;
            d.w_strb = wstrb;
        end
        if (q.bvalid && bready)
            d.bvalid = 1'b0;
        if (q.aw_have && q.w_have && !q.bvalid)
        begin
            for (int b = 0; b < 4; b++)
                wd[8*b +: 8] = q.w_strb[b] ? q.w_data[8*b +: 8]
                                           : wcur[8*b +: 8];
            case ({q.aw_addr[7:2], 2'b00})
                `FPC_A_CTRL:   d.ctrl = {1'b0, wd[6:2],
                                         (wd[1:0] == 2'h3) ? 2'h0 : wd[1:0]};
                `FPC_A_DIMATT: d.dim_att = wd[5:0];
                `FPC_A_GAIN:   d.gain = wd[23:0];
                `FPC_A_LEVEL:  d.lvl = wd[20:0];
                `FPC_A_BAL:    d.bal = wd[14:0];
                `FPC_A_SAVED:  d.saved = wd[6:0];
                `FPC_A_MON:    d.mon[mi] = wd[5:0];
                `FPC_A_EVENT:  d.events = q.events &
                                   ~(q.w_strb[0] ? q.w_data[2:0] : 3'h0);
                default:       ;
            endcase
            d.aw_have = 1'b0;
            d.w_have = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = wcur[32] ? `FPC_RESP_OK : `FPC_RESP_ERR;
        end
        d.awready = !d.aw_have && !d.bvalid;
        d.wready = !d.w_have && !d.bvalid;

        if (q.rvalid && rready)
            d.rvalid = 1'b0;
        if (arvalid && q.arready)
        begin
            d.rvalid = 1'b1;
            d.rdata = rcur[31:0];
            d.rresp = rcur[32] ? `FPC_RESP_OK : `FPC_RESP_ERR;
        end
        d.arready = !d.rvalid;

        if (!q.key[`FPC_K_ATT] || combo)
        begin
            d.hold_dim = 12'h000;
            d.dim_fired = 1'b0;
        end
        else if (tick && !q.dim_fired)
        begin
            d.hold_dim = q.hold_dim + 12'h001;
            if (q.hold_dim == 12'(HOLD_TICKS - 1))
            begin
                d.dim_fired = 1'b1;
                d.lvl[main_sel] = q.saved;
            end
        end
        if (!q.key[`FPC_K_STO] || remap[2])
        begin
            d.hold_set = 12'h000;
            d.set_fired = 1'b0;
        end
        else if (tick && !q.set_fired)
        begin
            d.hold_set = q.hold_set + 12'h001;
            if (q.hold_set == 12'(HOLD_TICKS - 1))
            begin
                d.set_fired = 1'b1;
                d.saved = q.lvl[main_sel];
            end
        end
        if (!combo || usb_present || !ext_power)
            d.hold_mode = 12'h000;
        else if (tick)
        begin
            d.hold_mode = q.hold_mode + 12'h001;
            if (q.hold_mode == 12'(HOLD_TICKS - 1))
            begin
                d.hold_mode = 12'h000;
                d.host_cc = !q.host_cc;
                d.st = fpc_pkg::FPC_BOOT;
                d.boot_cnt = 12'h000;
            end
        end

        if (q.st == fpc_pkg::FPC_BOOT)
        begin
            if (!q.booted)
            begin
                d.booted = 1'b1;
                if (kraw[`FPC_K_STEP] && kraw[`FPC_K_ATT])
                    d.host_cc = !q.host_cc;
            end
            if (tick)
                d.boot_cnt = q.boot_cnt + 12'h001;
            if (q.boot_cnt == 12'(BOOT_TICKS - 1))
                d.st = fpc_pkg::FPC_OUT;
        end
        else
        begin
            if (press[`FPC_K_SRC])
            begin
                if (q.key[`FPC_K_STEP])
                    d.bright = (q.bright == 2'h2) ? 2'h0
                                                  : q.bright + 2'h1;
                else
                begin
                    d.in_sel = (q.in_sel == `FPC_OPT_SRC) ? 2'h0
                                                         : q.in_sel + 2'h1;
                    if (q.st != fpc_pkg::FPC_MON)
                        d.st = fpc_pkg::FPC_GAIN;
                end
            end
            if (press[`FPC_K_TGT])
            begin
                if (remap[0])
                    d.events[0] = 1'b1;
                else
                begin
                    d.out_sel = (q.out_sel == 2'h2) ? 2'h0
                                                    : q.out_sel + 2'h1;
                    if (q.st != fpc_pkg::FPC_MON)
                        d.st = fpc_pkg::FPC_OUT;
                end
            end
            if (press[`FPC_K_STEP])
            begin
                if (q.st == fpc_pkg::FPC_GAIN || q.st == fpc_pkg::FPC_MON)
                    d.in_ch = (q.in_ch == 2'h2) ? 2'h0
                                                : q.in_ch + 2'h1;
                if (q.st == fpc_pkg::FPC_FMT)
                    d.opt_8ch = !q.opt_8ch;
            end
            if (press[`FPC_K_ATT] && !q.key[`FPC_K_STEP])
                d.dim_on = !q.dim_on;
            if (press[`FPC_K_STO])
            begin
                if (remap[2])
                    d.events[2] = 1'b1;
                else if (q.st == fpc_pkg::FPC_FMT)
                    d.st = fpc_pkg::FPC_OUT;
                else if (q.st == fpc_pkg::FPC_OUT &&
                         q.out_sel == `FPC_OPT_OUT)
                    d.st = fpc_pkg::FPC_FMT;
            end
            if (press[`FPC_K_MON])
            begin
                if (remap[1])
                    d.events[1] = 1'b1;
                else
                    d.st = (q.st == fpc_pkg::FPC_MON) ? fpc_pkg::FPC_OUT
                                                      : fpc_pkg::FPC_MON;
            end
            if (up || dn)
            begin
                case (q.st)
                    fpc_pkg::FPC_GAIN:
                        if (q.in_sel != `FPC_OPT_SRC)
                            for (int c = 0; c < 2; c++)
                                if (q.in_ch == 2'h2 || q.in_ch == 2'(c))
                                    d.gain[{q.in_sel[0], 1'(c)}] = 6'(stepv(
                                        7'(q.gain[{q.in_sel[0], 1'(c)}]),
                                        up, `FPC_GAIN_MAX));
                    fpc_pkg::FPC_OUT:
                        if (q.key[`FPC_K_STEP])
                            d.bal[q.out_sel] = 5'(stepv(7'(q.bal[q.out_sel]),
                                up, `FPC_BAL_MAX));
                        else
                            d.lvl[q.out_sel] = stepv(q.lvl[q.out_sel], up,
                                `FPC_LVL_MAX);
                    fpc_pkg::FPC_MON:
                        d.mon[mi] = 6'(stepv(7'(q.mon[mi]), up,
                            `FPC_MON_MAX));
                    default: ;
                endcase
            end
        end

        att = q.dim_on ? 7'(q.dim_att) : 7'h00;
        d.main_lvl = (q.lvl[main_sel] > att) ? q.lvl[main_sel] - att
                                             : 7'h00;

        for (int b = 0; b < 4; b++)
            d.meter[b] = bar(band_level[b]);
        case (q.st)
            fpc_pkg::FPC_BOOT:
                d.meter = {4{q.host_cc ? `FPC_PAT_CC : `FPC_PAT_DRV}};
            fpc_pkg::FPC_GAIN:
                for (int c = 0; c < 2; c++)
                    if (q.in_ch == 2'h2 || q.in_ch == 2'(c))
                        d.meter[c] = flash ? dot(
                            q.gain[{q.in_sel[0], 1'(c)}][5:3]) : 8'h00;
            fpc_pkg::FPC_OUT:
                if (q.key[`FPC_K_STEP])
                begin
                    d.meter[2] = `FPC_BAR_YEL;
                    d.meter[3] = `FPC_BAR_YEL;
                end
                else
                begin
                    d.meter[2] = flash ? dot(q.lvl[q.out_sel][6:4])
                                       : 8'h00;
                    d.meter[3] = d.meter[2];
                end
            fpc_pkg::FPC_MON:
                for (int c = 0; c < 2; c++)
                    if ((q.in_ch == 2'h2 || q.in_ch == 2'(c)) && !flash)
                        d.meter[c] = 8'h00;
            fpc_pkg::FPC_FMT:
            begin
                d.meter[2] = q.opt_8ch ? `FPC_FMT_8CH : `FPC_FMT_2CH;
                d.meter[3] = d.meter[2];
            end
            default: ;
        endcase
        if (q.st == fpc_pkg::FPC_GAIN || q.st == fpc_pkg::FPC_OUT ||
            q.st == fpc_pkg::FPC_MON)
        begin
            d.meter[0][0] = q.ctrl[5];
            d.meter[1][0] = q.ctrl[6];
            d.meter[2][0] = q.dim_on && q.out_sel == main_sel;
            d.meter[3][0] = d.meter[2][0];
        end
        if (!host_online && q.in_sel == `FPC_OPT_SRC &&
            (q.st == fpc_pkg::FPC_GAIN || q.st == fpc_pkg::FPC_OUT))
        begin
            d.meter[0] = opt_in_8ch ? `FPC_FMT_8CH : `FPC_FMT_2CH;
            d.meter[1] = d.meter[0];
        end
        if (q.st != fpc_pkg::FPC_BOOT)
        begin
            d.meter[0][`FPC_CLIP_BIT] = |in_clip;
            d.meter[1][`FPC_CLIP_BIT] = |in_clip;
            d.meter[2][`FPC_CLIP_BIT] = |out_clip;
            d.meter[3][`FPC_CLIP_BIT] = |out_clip;
        end

        d.opt_y = !opt_lock;
        d.opt_g = opt_lock && (opt_sync || flash);
        d.pwm_cnt = q.pwm_cnt + 2'h1;
        case (q.bright)
            2'h2:    d.pwm_on = 1'b1;
            2'h1:    d.pwm_on = !q.pwm_cnt[0];
            default: d.pwm_on = (q.pwm_cnt == 2'h0);
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            q <= '0;
            q.st <= fpc_pkg::FPC_BOOT;
            q.bal <= {3{`FPC_BAL_RST}};
            q.lvl <= {3{`FPC_LVL_RST}};
            q.saved <= `FPC_LVL_RST;
            q.opt_8ch <= 1'b1;
            q.awready <= 1'b1;
            q.wready <= 1'b1;
            q.arready <= 1'b1;
        end
        else
            q <= d;
    end

    assign awready = q.awready;
    assign wready = q.wready;
    assign bvalid = q.bvalid;
    assign bresp = q.bresp;
    assign arready = q.arready;
    assign rvalid = q.rvalid;
    assign rdata = q.rdata;
    assign rresp = q.rresp;
    assign meter = q.meter;
    assign opt_led_yellow = q.opt_y;
    assign opt_led_green = q.opt_g;
    assign led_pwm = q.pwm_on;
    assign dim_active = q.dim_on;
    assign host_cc_mode = q.host_cc;
    assign main_level = q.main_lvl;
endmodule // fpc_front_panel

/* File: fpc_props.sv */
// Concurrent checks on the ports of the front-panel controller.
`timescale 1ns/1ns
`include "fpc_consts.svh"
module fpc_props (
    input wire logic            aclk,
    input wire logic            aresetn,
    input wire logic            usb_present,
    input wire logic            ext_power,
    input wire logic            opt_lock,
    input wire logic            opt_sync,
    input wire logic [2:0]      in_clip,
    input wire logic [2:0]      out_clip,
    input wire logic [3:0][7:0] meter,
    input wire logic            opt_led_green,
    input wire logic            led_pwm,
    input wire logic            host_cc_mode
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_in; (|in_clip) [*2] |=> meter[0][7] | meter[1][7]; endproperty
    a_in: assert property (p_in) else $error("input clip not shown");
    property p_out; (|out_clip) [*2] |=> meter[2][7] | meter[3][7]; endproperty
    a_out: assert property (p_out) else $error("output clip unseen");
    property p_sync; (opt_lock && opt_sync) [*3] |=> opt_led_green; endproperty
    a_sync: assert property (p_sync) else $error("sync not green");
    property p_nolock; (!opt_lock) [*3] |=> !opt_led_green; endproperty
    a_nolock: assert property (p_nolock) else $error("green, no lock");
    property p_boot; $rose(aresetn) |-> ##3
        meter[0] == (host_cc_mode ? `FPC_PAT_CC : `FPC_PAT_DRV); endproperty
    a_boot: assert property (p_boot) else $error("mode not shown");
    property p_usb; $changed(host_cc_mode) && $past(aresetn, 3)
        |-> !$past(usb_present); endproperty
    a_usb: assert property (p_usb) else $error("mode change on usb");
    property p_ext; $changed(host_cc_mode) && $past(aresetn, 3)
        |-> $past(ext_power); endproperty
    a_ext: assert property (p_ext) else $error("mode change, no supply");
    property p_pwm; $rose(led_pwm) |-> ##4 led_pwm; endproperty
    a_pwm: assert property (p_pwm) else $error("pwm period broken");
    c_mode: cover property ($changed(host_cc_mode));
    c_clip: cover property (|in_clip && |out_clip);
    c_sync: cover property (opt_lock && opt_sync);
endmodule // fpc_props
bind fpc_front_panel fpc_props u_props (.aclk, .aresetn, .usb_present,
    .ext_power, .opt_lock, .opt_sync, .in_clip, .out_clip, .meter,
    .opt_led_green, .led_pwm, .host_cc_mode);

/* File: fpc_user.sv */
// Model of the user at the keys and the encoder.
`timescale 1ns/1ns
module fpc_user (
    input  wire logic          aclk,
    output fpc_pkg::fpc_keys_t keys,
    output logic               enc_a,
    output logic               enc_b
);
    initial {keys, enc_a, enc_b} = 8'h00;
    task automatic hold(input logic [5:0] k1, k2, input int cyc);
        @(posedge aclk);
        keys <= k1;
        repeat (24) @(posedge aclk);
        keys <= k2;
        repeat (cyc) @(posedge aclk);
        keys <= 6'h00;
        repeat (24) @(posedge aclk);
    endtask
    task automatic turn(input logic down);
        @(posedge aclk) enc_b <= down;
        @(posedge aclk) enc_a <= 1'h1;
        repeat (2) @(posedge aclk);
        enc_a <= 1'h0;
    endtask
endmodule // fpc_user

/* File: front_panel_controller_test.sv */
// Self-checking bench of the front-panel controller.
`timescale 1ns/1ns
module front_panel_controller_test;
    typedef struct {logic [7:0] a; logic [31:0] m, e; logic [1:0] r;} fpc_row_t;
    localparam logic [5:0] SRC = 6'h01, TGT = 6'h02, STP = 6'h04;
    localparam logic [5:0] ATT = 6'h08, STO = 6'h10;
    logic aclk, aresetn, enc_a, enc_b, host_online, usb_present, ext_power;
    logic opt_lock, opt_sync, opt_in_8ch, awvalid, awready, wvalid, wready;
    logic bvalid, bready, arvalid, arready, rvalid, rready, opt_led_yellow;
    logic opt_led_green, led_pwm, dim_active, host_cc_mode, aw, w;
    logic [3:0][2:0]    band_level;
    logic [2:0]         in_clip, out_clip;
    logic [7:0]         awaddr, araddr;
    logic [31:0]        wdata, rdata, rv;
    logic [3:0]         wstrb;
    logic [1:0]         bresp, rresp, rs;
    logic [3:0][7:0]    meter;
    logic [6:0]         main_level;
    fpc_pkg::fpc_keys_t keys;
    int                 n_errors, compares;
    fpc_row_t rows [6] = '{'{8'h08, 32'hFFFF, 32'h44, 2'h0},
        '{8'h10, 32'h1FFFFF, 32'h102040, 2'h0},
        '{8'h14, 32'h7FFF, 32'h4210, 2'h0},
        '{8'h0C, 32'hFFFFFF, 32'h0, 2'h0},
        '{8'h18, 32'h7F, 32'h40, 2'h0},
        '{8'h24, 32'hFFFFFFFF, 32'h0, 2'h2}};
    fpc_front_panel #(.TICK_CYC(4), .HOLD_TICKS(8), .BOOT_TICKS(4)) dut (.*);
    fpc_user user (.*);
    always #5 aclk = ~aclk;
    task automatic chk(input string nm, input logic [31:0] exp, got);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, d, 7'h7F};
        {aw, w} = 2'h0;
        while (!(aw && w))
        begin
            @(posedge aclk);
            {aw, w} = {aw | awready, w | wready};
            {awvalid, wvalid} <= {!aw, !w};
        end
        do @(posedge aclk); while (!bvalid);
        bready <= 1'h0;
    endtask
    task automatic rc(input string nm, input logic [7:0] a,
                      input logic [31:0] m, e);
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 2'h3};
        do @(posedge aclk); while (!arready);
        arvalid <= 1'h0;
        do @(posedge aclk); while (!rvalid);
        {rv, rs} = {rdata, rresp};
        rready <= 1'h0;
        chk(nm, e, rv & m);
    endtask
    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        {aclk, aresetn, host_online, usb_present, opt_lock, opt_sync} = 6'h00;
        {awvalid, wvalid, bready, arvalid, rready, in_clip, out_clip} = 11'h000;
        {awaddr, araddr, wdata, wstrb, band_level} = 64'h0;
        {ext_power, opt_in_8ch, n_errors, compares} = {2'h3, 64'h0};
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (30) @(posedge aclk);
        foreach (rows[i])
        begin
            rc("reg", rows[i].a, rows[i].m, rows[i].e);
            chk("resp", 32'(rows[i].r), 32'(rs));
        end
        $display("reset values done");
        user.hold(TGT, TGT, 8);
        rc("out_sel", 8'h08, 32'h301F, 32'h1004);
        user.hold(SRC, SRC, 8);
        rc("in_sel", 8'h08, 32'hC1F, 32'h402);
        user.hold(STP, STP, 8);
        rc("in_ch", 8'h08, 32'hC000, 32'h4000);
        user.turn(1'h0);
        rc("gain", 8'h0C, 32'hFFFFFF, 32'h40000);
        repeat (2) user.hold(STP, STP | SRC, 24);
        rc("bright", 8'h08, 32'h180, 32'h100);
        repeat (2) user.hold(TGT, TGT, 8);
        wr(8'h04, 32'h3);
        wr(8'h18, 32'h10);
        user.hold(ATT, ATT, 60);
        chk("dim", 32'h1, 32'(dim_active));
        chk("recall", 32'hD, 32'(main_level));
        user.hold(ATT, ATT, 8);
        wr(8'h10, 32'h102025);
        user.hold(STO, STO, 60);
        rc("store", 8'h18, 32'h7F, 32'h25);
        chk("undim", 32'h25, 32'(main_level));
        repeat (2) user.hold(TGT, TGT, 8);
        user.hold(STO, STO, 8);
        rc("fmt_view", 8'h08, 32'h1F, 32'h10);
        user.hold(STP, STP, 8);
        rc("fmt_2ch", 8'h08, 32'h40, 32'h0);
        user.hold(STO, STO, 8);
        $display("keys done");
        chk("yellow", 32'h1, 32'(opt_led_yellow));
        {in_clip, out_clip, opt_lock, opt_sync} <= 8'h93;
        repeat (6) @(posedge aclk);
        chk("in_clip", 32'h1, 32'(meter[0][7] | meter[1][7]));
        chk("out_clip", 32'h1, 32'(meter[2][7] | meter[3][7]));
        chk("sync", 32'h1, 32'(opt_led_green));
        {in_clip, out_clip} <= 6'h00;
        usb_present <= 1'h1;
        user.hold(STP, STP | ATT, 60);
        chk("usb_refuse", 32'h0, 32'(host_cc_mode));
        usb_present <= 1'h0;
        user.hold(STP, STP | ATT, 60);
        chk("mode", 32'h1, 32'(host_cc_mode));
        aresetn <= 1'h0;
        fork
            user.hold(STP, STP | ATT, 8);
            begin
                repeat (28) @(posedge aclk);
                aresetn <= 1'h1;
                repeat (5) @(posedge aclk);
                chk("boot", 32'h3C, 32'(meter[0]));
            end
        join
        chk("power_on", 32'h1, 32'(host_cc_mode));
        $display("mode done");
        report_and_stop();
    end
    // The run needs about 1400 cycles; twenty times that means a hang.
    initial
    begin
        #300000;
        n_errors++;
        report_and_stop();
    end
endmodule // front_panel_controller_test
